// file: hdl/pts_pkg.sv
package pts_pkg;
    // -------------------------------------------------------------------------
    // fixed-point formats
    // -------------------------------------------------------------------------
    localparam int unsigned PTS_FRAC_BITS = 16;
    localparam int unsigned PTS_VAL_W = 48;
    localparam logic [47:0] PTS_PICKUP_RST = 48'h00000000028f;
    localparam int unsigned PTS_HYST_FRAC_BITS = 20;
    localparam logic [25:0] PTS_HYST_RST = 26'h0007ae1;
    // -------------------------------------------------------------------------
    // timing
    // -------------------------------------------------------------------------
    localparam int unsigned PTS_CLK_HZ = 10000000;
    localparam int unsigned PTS_TICK_US = 5000;
    localparam int unsigned PTS_TICK_CYC = (PTS_TICK_US * (PTS_CLK_HZ / 1000000)) / 1000000 * 0 +
        PTS_TICK_US * (PTS_CLK_HZ / 1000000);
    localparam int unsigned PTS_DELTA_MS = 20;
    localparam int unsigned PTS_DELTA_TICKS = (PTS_DELTA_MS * 1000) / PTS_TICK_US;
    localparam logic [18:0] PTS_OP_DLY_RST = 19'h00008;
    localparam logic [18:0] PTS_REL_DLY_RST = 19'h0000c;
    localparam logic [18:0] PTS_DLY_MAX = 19'h57e40;
    // -------------------------------------------------------------------------
    // encodings
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        PTS_CMP_OVER = 3'h0, PTS_CMP_OVER_ABS = 3'h1, PTS_CMP_UNDER = 3'h2, PTS_CMP_UNDER_ABS = 3'h3,
        PTS_CMP_DREL = 3'h4, PTS_CMP_DREL_ABS = 3'h5, PTS_CMP_DVAL = 3'h6, PTS_CMP_DVAL_ABS = 3'h7
    } pts_cmp_mode_t;
    typedef enum logic [1:0] {
        PTS_COND_NORMAL = 2'h0, PTS_COND_START = 2'h1, PTS_COND_TRIP = 2'h2, PTS_COND_BLOCKED = 2'h3
    } pts_cond_t;
    typedef enum logic [2:0] {
        PTS_NODE_ON = 3'h1, PTS_NODE_BLOCKED = 3'h2, PTS_NODE_TEST = 3'h3,
        PTS_NODE_TEST_BLK = 3'h4, PTS_NODE_OFF = 3'h5
    } pts_node_t;
    typedef enum logic [1:0] {
        PTS_ST_IDLE = 2'h0, PTS_ST_START = 2'h1, PTS_ST_TRIP = 2'h3, PTS_ST_BLOCK = 2'h2
    } pts_state_t;
endpackage : pts_pkg

// file: hdl/pts_stage.sv
`timescale 1ns/1ns
module pts_stage
    import pts_pkg::*;
#(
    parameter int unsigned NUM_MEAS = 3
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [1:0] meas_count,
    input wire logic signed [47:0] meas_value [3],
    input wire logic signed [47:0] mag_multiplier [3],
    input wire logic [2:0] cmp_mode [3],
    input wire logic signed [47:0] pickup_level [3],
    input wire logic [25:0] hyst_setting [3],
    input wire logic signed [47:0] block_limit [3],
    input wire logic signed [47:0] combined_pickup,
    input wire logic [18:0] op_delay_ticks,
    input wire logic [18:0] rel_delay_ticks,
    input wire logic block_in,
    input wire logic test_mode,
    input wire logic stage_enable,
    output logic [2:0] node_operating_state,
    output logic [1:0] condition,
    output logic start_out,
    output logic trip_out,
    output logic blocked_out,
    output logic [18:0] expected_op_ticks,
    output logic [18:0] remaining_ticks,
    output logic signed [47:0] scaled_magnitude [3],
    output logic signed [47:0] meas_ratio [3],
    output logic signed [47:0] combined_magnitude,
    output logic signed [47:0] combined_ratio
);
    initial begin
        if (NUM_MEAS != 3) $error("pts_stage serves exactly three measurement slots");
    end
    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic blk_s1;
        logic blk_s2;
        logic [15:0] tick_cnt;
        pts_state_t st;
        logic [18:0] op_cnt;
        logic [18:0] rel_cnt;
        logic [2:0] pick;
        logic [2:0][47:0] scaled;
        logic [2:0][47:0] hist;
        logic [2:0] hist_cnt;
        logic [2:0][47:0] ratio;
        logic [47:0] comb;
        logic [47:0] comb_ratio;
    } pts_regs_t;
    pts_regs_t s_r;
    pts_regs_t s_nxt;

    function automatic logic signed [47:0] pts_abs(input logic signed [47:0] v);
        pts_abs = v[47] ? -v : v;
    endfunction : pts_abs

    function automatic logic signed [47:0] pts_fix_div(input logic signed [47:0] n,
                                                       input logic signed [47:0] d);
        logic signed [63:0] wide;
        wide = 64'(n) <<< PTS_FRAC_BITS;
        pts_fix_div = (d == 48'sh0) ? 48'sh0 : 48'(wide / 64'(d));
    endfunction : pts_fix_div

    function automatic logic signed [47:0] pts_rel_thr(input logic signed [47:0] p,
                                                       input logic signed [47:0] h);
        logic signed [95:0] wide;
        wide = (96'(pts_abs(p)) * 96'(pts_abs(h))) / 96'sh64;
        pts_rel_thr = 48'(wide >>> PTS_FRAC_BITS);
    endfunction : pts_rel_thr

    logic tick;
    logic pick_any;
    logic signed [95:0] prod [3];
    logic signed [47:0] hyst_amt [3];
    logic raw_pick [3];
    logic [2:0] used;
    logic signed [47:0] dlt [3];
    logic signed [47:0] cur [3];
    logic signed [47:0] rel_thr [3];

    assign tick = (s_r.tick_cnt == 16'(PTS_TICK_CYC - 1));
    // -------------------------------------------------------------------------
    // comparators
    // -------------------------------------------------------------------------
    generate
        for (genvar i = 0; i < 3; i++) begin : g_cmp
            assign used[i] = (2'(i) < meas_count);
            assign prod[i] = meas_value[i] * mag_multiplier[i];
            assign hyst_amt[i] = 48'((96'(pts_abs(pickup_level[i])) * 96'(hyst_setting[i]))
                                 >>> PTS_HYST_FRAC_BITS);
            always_comb begin
                cur[i] = s_r.scaled[i];
                dlt[i] = cur[i] - s_r.hist[i];
                rel_thr[i] = pts_rel_thr(pickup_level[i], s_r.hist[i]);
                raw_pick[i] = 1'b0;
                case (pts_cmp_mode_t'(cmp_mode[i]))
                    PTS_CMP_OVER:
                        raw_pick[i] = s_r.pick[i] ? (cur[i] > pickup_level[i] - hyst_amt[i])
                                                  : (cur[i] > pickup_level[i]);
                    PTS_CMP_OVER_ABS:
                        raw_pick[i] = s_r.pick[i] ? (pts_abs(cur[i]) > pickup_level[i] - hyst_amt[i])
                                                  : (pts_abs(cur[i]) > pickup_level[i]);
                    PTS_CMP_UNDER:
                        raw_pick[i] = (cur[i] >= block_limit[i]) && (s_r.pick[i] ?
                            (cur[i] < pickup_level[i] + hyst_amt[i]) : (cur[i] < pickup_level[i]));
                    PTS_CMP_UNDER_ABS:
                        raw_pick[i] = (cur[i] >= block_limit[i]) && (s_r.pick[i] ?
                            (pts_abs(cur[i]) < pickup_level[i] + hyst_amt[i])
                            : (pts_abs(cur[i]) < pickup_level[i]));
                    PTS_CMP_DREL:
                        raw_pick[i] = pickup_level[i][47] ? (dlt[i] < -rel_thr[i]) : (dlt[i] > rel_thr[i]);
                    PTS_CMP_DREL_ABS:
                        raw_pick[i] = pts_abs(dlt[i]) > rel_thr[i];
                    PTS_CMP_DVAL:
                        raw_pick[i] = pickup_level[i][47] ? (dlt[i] < pickup_level[i])
                                                          : (dlt[i] > pickup_level[i]);
                    PTS_CMP_DVAL_ABS:
                        raw_pick[i] = pts_abs(dlt[i]) > pts_abs(pickup_level[i]);
                    default:
                        raw_pick[i] = 1'b0;
                endcase
            end
        end
    endgenerate

    assign pick_any = |(s_r.pick & used);
    // -------------------------------------------------------------------------
    // next state
    // -------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.blk_s1 = block_in;
        s_nxt.blk_s2 = s_r.blk_s1;
        s_nxt.tick_cnt = tick ? 16'h0000 : s_r.tick_cnt + 16'h0001;
        s_nxt.comb = 48'sh0;
        for (int k = 0; k < 3; k++) begin
            s_nxt.scaled[k] = 48'(prod[k] >>> PTS_FRAC_BITS);
            s_nxt.ratio[k] = pts_fix_div(s_r.scaled[k], pickup_level[k]);
            s_nxt.pick[k] = used[k] & raw_pick[k];
            if (used[k]) begin
                s_nxt.comb = s_nxt.comb + s_r.scaled[k];
            end
        end
        s_nxt.comb_ratio = pts_fix_div(s_r.comb, combined_pickup);
        if (tick) begin
            s_nxt.hist_cnt = (s_r.hist_cnt == 3'(PTS_DELTA_TICKS - 1)) ? 3'h0 : s_r.hist_cnt + 3'h1;
            if (s_r.hist_cnt == 3'h0) begin
                s_nxt.hist = s_r.scaled;
            end
        end
        case (s_r.st)
            PTS_ST_IDLE: begin
                s_nxt.op_cnt = 19'h0;
                s_nxt.rel_cnt = 19'h0;
                if (stage_enable && pick_any) begin
                    s_nxt.st = s_r.blk_s2 ? PTS_ST_BLOCK : PTS_ST_START;
                end
            end
            PTS_ST_START: begin
                if (s_r.blk_s2 || !stage_enable) begin
                    s_nxt.st = PTS_ST_BLOCK;
                end else if (!pick_any) begin
                    s_nxt.st = PTS_ST_IDLE;
                end else if (tick) begin
                    if (s_r.op_cnt + 19'h1 >= expected_op_ticks) begin
                        s_nxt.st = PTS_ST_TRIP;
                        s_nxt.rel_cnt = 19'h0;
                    end else begin
                        s_nxt.op_cnt = s_r.op_cnt + 19'h1;
                    end
                end
            end
            PTS_ST_TRIP: begin
                if (pick_any && stage_enable) begin
                    s_nxt.rel_cnt = 19'h0;
                end else if (tick) begin
                    if (s_r.rel_cnt + 19'h1 >= rel_delay_ticks) begin
                        s_nxt.st = PTS_ST_IDLE;
                    end else begin
                        s_nxt.rel_cnt = s_r.rel_cnt + 19'h1;
                    end
                end
            end
            PTS_ST_BLOCK: begin
                if (!pick_any || !stage_enable) begin
                    if (tick) begin
                        if (s_r.rel_cnt + 19'h1 >= rel_delay_ticks) begin
                            s_nxt.st = PTS_ST_IDLE;
                        end else begin
                            s_nxt.rel_cnt = s_r.rel_cnt + 19'h1;
                        end
                    end
                end else begin
                    s_nxt.rel_cnt = 19'h0;
                end
            end
            default: s_nxt.st = PTS_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign start_out = (s_r.st == PTS_ST_START) || (s_r.st == PTS_ST_TRIP);
    assign trip_out = (s_r.st == PTS_ST_TRIP);
    assign blocked_out = (s_r.st == PTS_ST_BLOCK);
    always_comb begin
        case (s_r.st)
            PTS_ST_START: condition = PTS_COND_START;
            PTS_ST_TRIP: condition = PTS_COND_TRIP;
            PTS_ST_BLOCK: condition = PTS_COND_BLOCKED;
            default: condition = PTS_COND_NORMAL;
        endcase
        if (!stage_enable) begin
            node_operating_state = PTS_NODE_OFF;
        end else if (test_mode) begin
            node_operating_state = s_r.blk_s2 ? PTS_NODE_TEST_BLK : PTS_NODE_TEST;
        end else begin
            node_operating_state = s_r.blk_s2 ? PTS_NODE_BLOCKED : PTS_NODE_ON;
        end
    end
    assign expected_op_ticks = (op_delay_ticks > PTS_DLY_MAX) ? PTS_DLY_MAX : op_delay_ticks;
    assign remaining_ticks = (s_r.st == PTS_ST_START && expected_op_ticks > s_r.op_cnt) ?
        expected_op_ticks - s_r.op_cnt : 19'h0;
    generate
        for (genvar j = 0; j < 3; j++) begin : g_out
            assign scaled_magnitude[j] = s_r.scaled[j];
            assign meas_ratio[j] = s_r.ratio[j];
        end
    endgenerate
    assign combined_magnitude = s_r.comb;
    assign combined_ratio = s_r.comb_ratio;
    // -------------------------------------------------------------------------
    // checks
    // -------------------------------------------------------------------------
    sequence s_idle_pick;
        s_r.st == PTS_ST_IDLE && stage_enable && pick_any;
    endsequence
    a_start_not_blocked: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_idle_pick and s_r.blk_s2 |=> !start_out && blocked_out) else $error("start while blocked");
    a_start_on_pick: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_idle_pick and !s_r.blk_s2 |=> start_out) else $error("pick-up did not start");
    a_trip_needs_start: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(trip_out) |-> $past(start_out)) else $error("trip without start");
    a_block_clears_start: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_r.st == PTS_ST_START && s_r.blk_s2 |=> !start_out) else $error("start held under block");
    a_cond_code: assert property (@(posedge sys_clk) disable iff (!arst_n)
        trip_out |-> condition == 2'h2) else $error("condition code wrong");
    a_node_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !stage_enable |-> node_operating_state == 3'h5) else $error("node state not off");
    a_remain_bound: assert property (@(posedge sys_clk) disable iff (!arst_n)
        remaining_ticks <= PTS_DLY_MAX) else $error("remaining time out of range");
    a_trip_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
        trip_out && pick_any && stage_enable |=> trip_out) else $error("trip dropped during pick-up");
    sequence s_trip_release;
        trip_out && !(pick_any && stage_enable) && tick && (s_r.rel_cnt + 19'h1 >= rel_delay_ticks);
    endsequence
    a_trip_release: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_trip_release |=> !trip_out) else $error("trip held past release delay");
    sequence s_start_lost;
        s_r.st == PTS_ST_START && !s_r.blk_s2 && stage_enable && !pick_any;
    endsequence
    a_start_drop: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_start_lost |=> !start_out) else $error("start held without pick-up");
    a_remain_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !start_out |-> remaining_ticks == 19'h0) else $error("remaining time shown while not counting");
    a_node_blocked: assert property (@(posedge sys_clk) disable iff (!arst_n)
        stage_enable && !test_mode && s_r.blk_s2 |-> node_operating_state == 3'h2)
        else $error("node state not blocked");
    a_blocked_code: assert property (@(posedge sys_clk) disable iff (!arst_n)
        blocked_out |-> condition == 2'h3) else $error("blocked condition code wrong");
endmodule : pts_stage

// file: verification/pts_meas_src.sv
`timescale 1ns/1ns
// -----------------------------------------------------------------------------
// measurement channels and blocking matrix seen by the stage
// -----------------------------------------------------------------------------
module pts_meas_src (
    input wire logic sys_clk,
    input wire logic signed [47:0] want_value [3],
    input wire logic want_block,
    output logic signed [47:0] meas_value [3],
    output logic block_in
);
    initial begin
        meas_value = '{default: 48'h0};
        block_in = 1'b0;
    end
    // new samples land away from the sampling edge
    always @(negedge sys_clk) begin
        meas_value <= want_value;
        block_in <= want_block;
    end
endmodule : pts_meas_src

// file: verification/test_programmable_threshold_stage.sv
`timescale 1ns/1ns
module test_programmable_threshold_stage;
    import pts_pkg::*;
    localparam longint ONE = 64'h10000;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [1:0] meas_count = 2'h1;
    logic signed [47:0] want_value [3] = '{default: 48'h0};
    logic want_block = 1'b0;
    logic signed [47:0] meas_value [3];
    logic block_in;
    logic signed [47:0] mag_multiplier [3] = '{default: 48'h10000};
    logic [2:0] cmp_mode [3] = '{default: 3'h0};
    logic signed [47:0] pickup_level [3] = '{default: PTS_PICKUP_RST};
    logic [25:0] hyst_setting [3] = '{default: PTS_HYST_RST};
    logic signed [47:0] block_limit [3] = '{default: 48'h0};
    logic signed [47:0] combined_pickup = 48'h10000;
    logic [18:0] op_delay_ticks = 19'h00001;
    logic [18:0] rel_delay_ticks = 19'h00001;
    logic test_mode = 1'b0;
    logic stage_enable = 1'b1;
    logic [2:0] node_operating_state;
    logic [1:0] condition;
    logic start_out;
    logic trip_out;
    logic blocked_out;
    logic [18:0] expected_op_ticks;
    logic [18:0] remaining_ticks;
    logic signed [47:0] scaled_magnitude [3];
    logic signed [47:0] meas_ratio [3];
    logic signed [47:0] combined_magnitude;
    logic signed [47:0] combined_ratio;
    int err_count = 0;
    int checks_done = 0;
    int i;
    int k;
    int n;
    longint sum;
    longint ev [3];
    logic [31:0] seed = 32'ha626;
    // mode, value, pick-up, blocking limit in whole units
    int vec [13][4] = '{'{0, 5, 4, -10}, '{0, -5, 4, -10}, '{1, -5, 4, -10}, '{1, 3, 4, -10},
        '{2, 3, 4, -10}, '{2, 3, 4, 4}, '{3, -3, 4, -10}, '{4, 5, 4, -10}, '{4, 5, -4, -10},
        '{5, -5, 4, -10}, '{6, 3, 4, -10}, '{6, -5, -4, -10}, '{7, -5, 4, -10}};

    pts_meas_src src (.sys_clk(sys_clk), .want_value(want_value), .want_block(want_block),
        .meas_value(meas_value), .block_in(block_in));
    pts_stage uut (.sys_clk(sys_clk), .arst_n(arst_n), .meas_count(meas_count), .meas_value(meas_value),
        .mag_multiplier(mag_multiplier), .cmp_mode(cmp_mode), .pickup_level(pickup_level),
        .hyst_setting(hyst_setting), .block_limit(block_limit), .combined_pickup(combined_pickup),
        .op_delay_ticks(op_delay_ticks), .rel_delay_ticks(rel_delay_ticks), .block_in(block_in),
        .test_mode(test_mode), .stage_enable(stage_enable), .node_operating_state(node_operating_state),
        .condition(condition), .start_out(start_out), .trip_out(trip_out), .blocked_out(blocked_out),
        .expected_op_ticks(expected_op_ticks), .remaining_ticks(remaining_ticks),
        .scaled_magnitude(scaled_magnitude), .meas_ratio(meas_ratio),
        .combined_magnitude(combined_magnitude), .combined_ratio(combined_ratio));

    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // -------------------------------------------------------------------------
    // reference model and helpers
    // -------------------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    function automatic bit exp_pick(input int m, input longint v, input longint p, input longint b);
        longint a;
        a = (v < 0) ? -v : v;
        case (m)
            0: return v > p;
            1: return a > p;
            2: return (v < p) && !(v < b);
            3: return (a < p) && !(v < b);
            // history is zero until the first 5 ms tick after reset takes the first sample, so the relative threshold is zero
            4: return (p < 0) ? (v < 0) : (v > 0);
            5: return a > 0;
            6: return (p < 0) ? (v < p) : (v > p);
            default: return a > ((p < 0) ? -p : p);
        endcase
    endfunction : exp_pick
    task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic do_reset;
        arst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
    endtask : do_reset
    task automatic report_and_stop;
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // -------------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------------
    initial begin
        do_reset();
        check("condition", 48'(PTS_COND_NORMAL), 48'(condition));
        check("node_state", 48'(PTS_NODE_ON), 48'(node_operating_state));
        for (i = 0; i < 13; i++) begin
            cmp_mode[0] = 3'(vec[i][0]);
            want_value[0] <= 48'(longint'(vec[i][1]) * ONE);
            pickup_level[0] = 48'(longint'(vec[i][2]) * ONE);
            block_limit[0] = 48'(longint'(vec[i][3]) * ONE);
            do_reset();
            repeat (10) @(negedge sys_clk);
            k = int'(exp_pick(vec[i][0], vec[i][1], vec[i][2], vec[i][3]));
            check("start_out", 48'(k), 48'(start_out));
        end
        cmp_mode[0] = 3'h0;
        want_value[0] <= 48'(5 * ONE);
        want_block <= 1'b1;
        do_reset();
        repeat (10) @(negedge sys_clk);
        check("blocked_out", 48'h1, 48'(blocked_out));
        check("start_out", 48'h0, 48'(start_out));
        check("condition", 48'(PTS_COND_BLOCKED), 48'(condition));
        check("node_state", 48'(PTS_NODE_BLOCKED), 48'(node_operating_state));
        test_mode = 1'b1;
        @(negedge sys_clk);
        check("node_state", 48'(PTS_NODE_TEST_BLK), 48'(node_operating_state));
        want_block <= 1'b0;
        repeat (6) @(negedge sys_clk);
        check("node_state", 48'(PTS_NODE_TEST), 48'(node_operating_state));
        stage_enable = 1'b0;
        @(negedge sys_clk);
        check("node_state", 48'(PTS_NODE_OFF), 48'(node_operating_state));
        stage_enable = 1'b1;
        test_mode = 1'b0;
        combined_pickup = 48'(2 * ONE);
        for (i = 0; i < 4; i++) begin
            seed = xs(seed);
            meas_count = 2'(seed % 3 + 1);
            sum = 0;
            for (k = 0; k < 3; k++) begin
                seed = xs(seed);
                ev[k] = longint'(seed % 4 + 1) * longint'((seed >> 8) % 8);
                mag_multiplier[k] = 48'(longint'(seed % 4 + 1) * ONE);
                want_value[k] <= 48'(longint'((seed >> 8) % 8) * ONE);
                pickup_level[k] = 48'(2 * ONE);
                if (k < int'(meas_count)) sum += ev[k];
            end
            repeat (6) @(negedge sys_clk);
            for (k = 0; k < 3; k++) begin
                check("scaled_magnitude", 48'(ev[k] * ONE), scaled_magnitude[k]);
                check("meas_ratio", 48'(ev[k] * ONE / 2), meas_ratio[k]);
            end
            check("combined_magnitude", 48'(sum * ONE), combined_magnitude);
            check("combined_ratio", 48'(sum * ONE / 2), combined_ratio);
        end
        meas_count = 2'h1;
        mag_multiplier[0] = 48'(ONE);
        pickup_level[0] = 48'(4 * ONE);
        want_value[0] <= 48'(5 * ONE);
        do_reset();
        for (n = 0; n < 20 && start_out !== 1'b1; n++) @(negedge sys_clk);
        check("start_out", 48'h1, 48'(start_out));
        check("expected_op_ticks", 48'(op_delay_ticks), 48'(expected_op_ticks));
        check("remaining_ticks", 48'(op_delay_ticks), 48'(remaining_ticks));
        want_value[0] <= 48'(4 * ONE - ONE / 20);
        repeat (6) @(negedge sys_clk);
        check("start_out", 48'h1, 48'(start_out));
        want_value[0] <= 48'(4 * ONE - ONE / 5);
        repeat (6) @(negedge sys_clk);
        check("start_out", 48'h0, 48'(start_out));
        want_value[0] <= 48'(5 * ONE);
        for (n = 0; n < 60000 && trip_out !== 1'b1; n++) @(negedge sys_clk);
        check("trip_out", 48'h1, 48'(trip_out));
        check("condition", 48'(PTS_COND_TRIP), 48'(condition));
        check("remaining_ticks", 48'h0, 48'(remaining_ticks));
        report_and_stop();
    end
endmodule : test_programmable_threshold_stage
